// file: rtl/gposel_top.sv
// gposel_top: three pin output selectors with register port
// assumes status inputs are synchronous to clock; direction bits come in
//
// Design decision made here: the plain strobed port.
`default_nettype none
//
// Functional notes
// - pin zero selector, bits 4..0 at 0x53, read/write, resets to zero.
// - selected signal reaches pin only when pin direction is output.
// - code 0110 gives clock error OR clock changing OR clock missing.
// - code 0111 gives serial audio output data.
// - codes 1000/1001 give left/right analog mute, both active low.
// - code 1010 gives pll lock.
// - code 1011 gives charge pump clock.
// - code 1110 gives undervoltage at 0.7 threshold, 1111 at 0.3.
// - codes 10010/10011 give left/right impedance sense.
// - code 10100 gives internal undervoltage flag, low below about 2.7V.
// - code 10101 gives offset calibration in progress.
// - codes 10110..11001 give clock error, changing, missing, halt.
// - code 11010 gives processor boot done.
// - code 11011 gives active-low charge pump voltage valid.
// - 0000 low, 0001 processor pin output, 0010 register pin bit.
// - 0011 both channels auto-muted, 0100/0101 left/right auto-mute.
// - pin two selector, bits 4..0 at 0x55, same code set.
module gposel_top
  import gposel_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [2:0] pin_dir_out,
  input  wire logic [2:0] dsp_pin_out,
  input  wire logic [2:0] reg_pin_bit,
  input  wire logic       automute_l,
  input  wire logic       automute_r,
  input  wire logic       clk_error,
  input  wire logic       clk_changing,
  input  wire logic       clk_missing,
  input  wire logic       clk_halt,
  input  wire logic       serial_audio_out,
  input  wire logic       anmute_l_n,
  input  wire logic       anmute_r_n,
  input  wire logic       pll_lock,
  input  wire logic       cp_clock,
  input  wire logic       uv_hi_thresh,
  input  wire logic       uv_lo_thresh,
  input  wire logic       imp_sense_l,
  input  wire logic       imp_sense_r,
  input  wire logic       undervoltage_indication,
  input  wire logic       offset_cal_busy,
  input  wire logic       boot_done,
  input  wire logic       cp_valid_n,
  output logic      [2:0] pin_out,
  output logic      [2:0] pin_oe_n
);
  import gposel_pkg::*;

  gposel_code_t pin_zero_signal_code;
  gposel_code_t pin_one_signal_code;
  gposel_code_t pin_two_signal_code;
  logic   [7:0] rsvd_84;
  gposel_code_t next_zero;
  gposel_code_t next_one;
  gposel_code_t next_two;
  logic   [7:0] next_rsvd;
  logic   [7:0] next_rdata;
  logic   [2:0] next_pin_out;
  logic   [2:0] next_pin_oe_n;

  // shared mux, one copy per pin
  function automatic logic pick(input gposel_code_t c, input int unsigned p);
    logic v;
    v = 1'b0;
    case (c)
      GPOSEL_OFF:        v = 1'b0;
      GPOSEL_DSP:        v = dsp_pin_out[p];
      GPOSEL_REGBIT:     v = reg_pin_bit[p];
      GPOSEL_AMUTE_BOTH: v = automute_l & automute_r;
      GPOSEL_AMUTE_L:    v = automute_l;
      GPOSEL_AMUTE_R:    v = automute_r;
      GPOSEL_CLK_INVAL:  v = clk_error | clk_changing | clk_missing;
      GPOSEL_SER_OUT:    v = serial_audio_out;
      GPOSEL_ANMUTE_L:   v = anmute_l_n;
      GPOSEL_ANMUTE_R:   v = anmute_r_n;
      GPOSEL_PLL_LOCK:   v = pll_lock;
      GPOSEL_CP_CLK:     v = cp_clock;
      GPOSEL_UV_HI:      v = uv_hi_thresh;
      GPOSEL_UV_LO:      v = uv_lo_thresh;
      GPOSEL_IMP_L:      v = imp_sense_l;
      GPOSEL_IMP_R:      v = imp_sense_r;
      GPOSEL_UVP_INT:    v = undervoltage_indication;
      GPOSEL_OFS_CAL:    v = offset_cal_busy;
      GPOSEL_CLK_ERR:    v = clk_error;
      GPOSEL_CLK_CHG:    v = clk_changing;
      GPOSEL_CLK_MISS:   v = clk_missing;
      GPOSEL_CLK_HALT:   v = clk_halt;
      GPOSEL_BOOT_DONE:  v = boot_done;
      GPOSEL_CP_VALID_N: v = cp_valid_n;
      default:           v = 1'b0;
    endcase
    return v;
  endfunction

  always_comb begin
    next_zero = pin_zero_signal_code;
    next_one  = pin_one_signal_code;
    next_two  = pin_two_signal_code;
    next_rsvd = rsvd_84;
    if (reg_wr) begin
      case (reg_addr)
        GPOSEL_OFS_PIN_ZERO: next_zero = reg_wdata[4:0];
        GPOSEL_OFS_PIN_ONE:  next_one  = reg_wdata[4:0];
        GPOSEL_OFS_PIN_TWO:  next_two  = reg_wdata[4:0];
        GPOSEL_OFS_RSVD_84:  next_rsvd = reg_wdata;
        default: ;
      endcase
    end
    // upper bits of the select registers are not stored, read zero
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        GPOSEL_OFS_PIN_ZERO: next_rdata = {3'h0, pin_zero_signal_code};
        GPOSEL_OFS_PIN_ONE:  next_rdata = {3'h0, pin_one_signal_code};
        GPOSEL_OFS_PIN_TWO:  next_rdata = {3'h0, pin_two_signal_code};
        GPOSEL_OFS_RSVD_84:  next_rdata = rsvd_84;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_pin_out[0] = pick(pin_zero_signal_code, 0);
    next_pin_out[1] = pick(pin_one_signal_code, 1);
    next_pin_out[2] = pick(pin_two_signal_code, 2);
    // an input pin shows nothing of the selection
    next_pin_oe_n = ~pin_dir_out;
    next_pin_out  = next_pin_out & pin_dir_out;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_zero_signal_code <= GPOSEL_CODE_RST;
      pin_one_signal_code  <= GPOSEL_CODE_RST;
      pin_two_signal_code  <= GPOSEL_CODE_RST;
      rsvd_84              <= GPOSEL_RSVD_RST;
      reg_rdata            <= 8'h00;
      pin_out              <= 3'h0;
      pin_oe_n             <= 3'h7;
    end else begin
      pin_zero_signal_code <= next_zero;
      pin_one_signal_code  <= next_one;
      pin_two_signal_code  <= next_two;
      rsvd_84              <= next_rsvd;
      reg_rdata            <= next_rdata;
      pin_out              <= next_pin_out;
      pin_oe_n             <= next_pin_oe_n;
    end
  end

  chk_gated_input_pin: assert property (@(posedge clock) disable iff (srst)
    !pin_dir_out[0] |=> !pin_out[0] && pin_oe_n[0])
    else $error("pin zero driven while input");
  chk_clk_invalid_or: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_CLK_INVAL && pin_dir_out[0]
    |=> pin_out[0] == $past(clk_error | clk_changing | clk_missing))
    else $error("clock invalid route wrong");
  chk_serial_route: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_SER_OUT && pin_dir_out[1]
    |=> pin_out[1] == $past(serial_audio_out))
    else $error("serial data route wrong");
  chk_anmute_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_ANMUTE_R && pin_dir_out[2]
    |=> pin_out[2] == $past(anmute_r_n))
    else $error("analog mute route wrong");
  chk_reserved_low: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code inside {5'h0c, 5'h0d, 5'h10, 5'h11, 5'h1c, 5'h1d,
                                 5'h1e, 5'h1f}
    |=> !pin_out[0])
    else $error("reserved code not low");
  chk_autom_both: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_AMUTE_BOTH && pin_dir_out[2]
    |=> pin_out[2] == $past(automute_l & automute_r))
    else $error("auto mute both route wrong");
  chk_write_zero_sel: assert property (@(posedge clock) disable iff (srst)
    reg_wr && reg_addr == GPOSEL_OFS_PIN_ZERO
    |=> pin_zero_signal_code == $past(reg_wdata[4:0]))
    else $error("pin zero select not written");
  chk_readback_two: assert property (@(posedge clock) disable iff (srst)
    reg_rd && reg_addr == GPOSEL_OFS_PIN_TWO && !reg_wr
    |=> reg_rdata == {3'h0, $past(pin_two_signal_code)})
    else $error("pin two readback wrong");
  chk_boot_route: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_BOOT_DONE && pin_dir_out[1]
    |=> pin_out[1] == $past(boot_done))
    else $error("boot done route wrong");
  chk_gated_pin_one: assert property (@(posedge clock) disable iff (srst)
    !pin_dir_out[1] |=> !pin_out[1] && pin_oe_n[1])
    else $error("pin one driven while input");
  chk_gated_pin_two: assert property (@(posedge clock) disable iff (srst)
    !pin_dir_out[2] |=> !pin_out[2] && pin_oe_n[2])
    else $error("pin two driven while input");
  chk_oe_follows_dir: assert property (@(posedge clock) disable iff (srst)
    1'b1 |=> pin_oe_n == ~$past(pin_dir_out))
    else $error("output enable not from direction");
  chk_off_code_low: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_OFF |=> !pin_out[1])
    else $error("off code not low");
  chk_dsp_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_DSP && pin_dir_out[2]
    |=> pin_out[2] == $past(dsp_pin_out[2]))
    else $error("processor pin route wrong");
  chk_regbit_route: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_REGBIT && pin_dir_out[0]
    |=> pin_out[0] == $past(reg_pin_bit[0]))
    else $error("register pin bit route wrong");
  chk_autom_left: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_AMUTE_L && pin_dir_out[0]
    |=> pin_out[0] == $past(automute_l))
    else $error("left auto mute route wrong");
  chk_autom_right: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_AMUTE_R && pin_dir_out[1]
    |=> pin_out[1] == $past(automute_r))
    else $error("right auto mute route wrong");
  chk_anmute_left: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_ANMUTE_L && pin_dir_out[0]
    |=> pin_out[0] == $past(anmute_l_n))
    else $error("left analog mute route wrong");
  chk_pll_route: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_PLL_LOCK && pin_dir_out[1]
    |=> pin_out[1] == $past(pll_lock))
    else $error("pll lock route wrong");
  chk_cp_clk_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_CP_CLK && pin_dir_out[2]
    |=> pin_out[2] == $past(cp_clock))
    else $error("charge pump clock route wrong");
  chk_uv_high_route: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_UV_HI && pin_dir_out[0]
    |=> pin_out[0] == $past(uv_hi_thresh))
    else $error("upper threshold route wrong");
  chk_uv_low_route: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_UV_LO && pin_dir_out[1]
    |=> pin_out[1] == $past(uv_lo_thresh))
    else $error("lower threshold route wrong");
  chk_imp_left_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_IMP_L && pin_dir_out[2]
    |=> pin_out[2] == $past(imp_sense_l))
    else $error("left impedance route wrong");
  chk_imp_right_route: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_IMP_R && pin_dir_out[0]
    |=> pin_out[0] == $past(imp_sense_r))
    else $error("right impedance route wrong");
  chk_uvp_route: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_UVP_INT && pin_dir_out[1]
    |=> pin_out[1] == $past(undervoltage_indication))
    else $error("internal undervoltage route wrong");
  chk_cal_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_OFS_CAL && pin_dir_out[2]
    |=> pin_out[2] == $past(offset_cal_busy))
    else $error("calibration route wrong");
  chk_clk_err_route: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_CLK_ERR && pin_dir_out[0]
    |=> pin_out[0] == $past(clk_error))
    else $error("clock error route wrong");
  chk_clk_chg_route: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code == GPOSEL_CLK_CHG && pin_dir_out[1]
    |=> pin_out[1] == $past(clk_changing))
    else $error("clock changing route wrong");
  chk_clk_miss_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_CLK_MISS && pin_dir_out[2]
    |=> pin_out[2] == $past(clk_missing))
    else $error("clock missing route wrong");
  chk_clk_halt_route: assert property (@(posedge clock) disable iff (srst)
    pin_zero_signal_code == GPOSEL_CLK_HALT && pin_dir_out[0]
    |=> pin_out[0] == $past(clk_halt))
    else $error("clock halt route wrong");
  chk_cp_valid_route: assert property (@(posedge clock) disable iff (srst)
    pin_two_signal_code == GPOSEL_CP_VALID_N && pin_dir_out[2]
    |=> pin_out[2] == $past(cp_valid_n))
    else $error("pump valid route wrong");
  chk_write_one_sel: assert property (@(posedge clock) disable iff (srst)
    reg_wr && reg_addr == GPOSEL_OFS_PIN_ONE
    |=> pin_one_signal_code == $past(reg_wdata[4:0]))
    else $error("pin one select not written");
  chk_write_two_sel: assert property (@(posedge clock) disable iff (srst)
    reg_wr && reg_addr == GPOSEL_OFS_PIN_TWO
    |=> pin_two_signal_code == $past(reg_wdata[4:0]))
    else $error("pin two select not written");
  chk_readback_zero: assert property (@(posedge clock) disable iff (srst)
    reg_rd && reg_addr == GPOSEL_OFS_PIN_ZERO
    |=> reg_rdata == {3'h0, $past(pin_zero_signal_code)})
    else $error("pin zero readback wrong");
  chk_readback_one: assert property (@(posedge clock) disable iff (srst)
    reg_rd && reg_addr == GPOSEL_OFS_PIN_ONE
    |=> reg_rdata == {3'h0, $past(pin_one_signal_code)})
    else $error("pin one readback wrong");
  chk_reserved_one_low: assert property (@(posedge clock) disable iff (srst)
    pin_one_signal_code inside {5'h0c, 5'h0d, 5'h10, 5'h11, 5'h1c, 5'h1d,
                                5'h1e, 5'h1f}
    |=> !pin_out[1])
    else $error("reserved code on pin one not low");
endmodule
`default_nettype wire

// file: rtl/gposel_pkg.sv
// gposel_pkg: offsets, code points and reset values of the pin selectors
// assumes an 8-bit register port with byte offsets as printed
`default_nettype none
package gposel_pkg;
  localparam logic [7:0] GPOSEL_OFS_PIN_ONE  = 8'h52;
  localparam logic [7:0] GPOSEL_OFS_PIN_ZERO = 8'h53;
  localparam logic [7:0] GPOSEL_OFS_RSVD_84  = 8'h54;
  localparam logic [7:0] GPOSEL_OFS_PIN_TWO  = 8'h55;
  localparam int         GPOSEL_CODE_LSB     = 0;
  localparam int         GPOSEL_CODE_W       = 5;
  localparam logic [4:0] GPOSEL_CODE_RST     = 5'h00;
  localparam logic [7:0] GPOSEL_RSVD_RST     = 8'h00;

  typedef logic [4:0] gposel_code_t;
  localparam gposel_code_t GPOSEL_OFF        = 5'h00;
  localparam gposel_code_t GPOSEL_DSP        = 5'h01;
  localparam gposel_code_t GPOSEL_REGBIT     = 5'h02;
  localparam gposel_code_t GPOSEL_AMUTE_BOTH = 5'h03;
  localparam gposel_code_t GPOSEL_AMUTE_L    = 5'h04;
  localparam gposel_code_t GPOSEL_AMUTE_R    = 5'h05;
  localparam gposel_code_t GPOSEL_CLK_INVAL  = 5'h06;
  localparam gposel_code_t GPOSEL_SER_OUT    = 5'h07;
  localparam gposel_code_t GPOSEL_ANMUTE_L   = 5'h08;
  localparam gposel_code_t GPOSEL_ANMUTE_R   = 5'h09;
  localparam gposel_code_t GPOSEL_PLL_LOCK   = 5'h0a;
  localparam gposel_code_t GPOSEL_CP_CLK     = 5'h0b;
  localparam gposel_code_t GPOSEL_UV_HI      = 5'h0e;
  localparam gposel_code_t GPOSEL_UV_LO      = 5'h0f;
  localparam gposel_code_t GPOSEL_IMP_L      = 5'h12;
  localparam gposel_code_t GPOSEL_IMP_R      = 5'h13;
  localparam gposel_code_t GPOSEL_UVP_INT    = 5'h14;
  localparam gposel_code_t GPOSEL_OFS_CAL    = 5'h15;
  localparam gposel_code_t GPOSEL_CLK_ERR    = 5'h16;
  localparam gposel_code_t GPOSEL_CLK_CHG    = 5'h17;
  localparam gposel_code_t GPOSEL_CLK_MISS   = 5'h18;
  localparam gposel_code_t GPOSEL_CLK_HALT   = 5'h19;
  localparam gposel_code_t GPOSEL_BOOT_DONE  = 5'h1a;
  localparam gposel_code_t GPOSEL_CP_VALID_N = 5'h1b;
endpackage
`default_nettype wire

// file: dv/gposel_pins.sv
// gposel_pins: outside circuit that watches the three selectable pins
// assumes a weak pull-down on each pin while the device releases it
`default_nettype none
module gposel_pins (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe_n,
  output logic      [2:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin falls to the pull-down, not to the last driven value
  always_comb level = ~pin_oe_n & pin_out;
endmodule
`default_nettype wire

// file: dv/gposel_top_tb.sv
// gposel_top_tb: register access and pin routing checks for gposel_top
// assumes registered read data and one cycle from input to pin
`default_nettype none
module gposel_top_tb
  import gposel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [2:0]  dir = 3'h0;
  logic [2:0]  pin_out, pin_oe_n, level, want;
  logic [20:0] s = '0;
  int          failures = 0;
  int          total_checks = 0;
  // source index per code, 21 means constant low
  localparam int idx [32] = '{21, 0, 1, 21, 2, 3, 21, 8, 9, 10, 11, 12,
    21, 21, 13, 14, 21, 21, 15, 16, 17, 18, 4, 5, 6, 7, 19, 20,
    21, 21, 21, 21};

  always #5 clock = ~clock;

  gposel_top i_dut (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_dir_out(dir), .dsp_pin_out({3{s[0]}}),
    .reg_pin_bit({3{s[1]}}), .automute_l(s[2]), .automute_r(s[3]),
    .clk_error(s[4]), .clk_changing(s[5]), .clk_missing(s[6]),
    .clk_halt(s[7]), .serial_audio_out(s[8]), .anmute_l_n(s[9]),
    .anmute_r_n(s[10]), .pll_lock(s[11]), .cp_clock(s[12]),
    .uv_hi_thresh(s[13]), .uv_lo_thresh(s[14]), .imp_sense_l(s[15]),
    .imp_sense_r(s[16]), .undervoltage_indication(s[17]),
    .offset_cal_busy(s[18]), .boot_done(s[19]), .cp_valid_n(s[20]),
    .pin_out, .pin_oe_n);
  gposel_pins i_pins (.pin_out, .pin_oe_n, .level);

  function automatic logic pick(input logic [4:0] c, input logic [20:0] v);
    logic [21:0] z;
    z = {1'b0, v};
    if (c == 5'h03) return v[2] & v[3];
    if (c == 5'h06) return |v[6:4];
    return z[idx[c]];
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp_v);
    total_checks++;
    if (seen !== exp_v) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp_v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp_v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp_v);
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(GPOSEL_OFS_PIN_ONE, 8'h00);
    rd(GPOSEL_OFS_PIN_ZERO, 8'h00);
    rd(GPOSEL_OFS_PIN_TWO, 8'h00);
    wr(GPOSEL_OFS_PIN_ZERO, 8'hff);
    wr(GPOSEL_OFS_RSVD_84, 8'ha5);
    wr(8'h60, 8'h3c);
    rd(GPOSEL_OFS_PIN_ZERO, 8'h1f);
    rd(GPOSEL_OFS_RSVD_84, 8'ha5);
    rd(8'h60, 8'h00);
    $display("register test done");
    // each pin gets its own code so crossed selectors show up
    for (int c = 0; c < 32; c++) begin
      wr(GPOSEL_OFS_PIN_ZERO, 8'(c));
      wr(GPOSEL_OFS_PIN_ONE, 8'((c + 1) % 32));
      wr(GPOSEL_OFS_PIN_TWO, 8'((c + 2) % 32));
      for (int k = 0; k < 22; k++) begin
        @(posedge clock);
        s <= (k == 21) ? '1 : 21'(1) << k;
        dir <= 3'h7 ^ (3'h1 << (k % 4));
        @(posedge clock);
        #1;
        for (int i = 0; i < 3; i++)
          want[i] = dir[i] & pick(5'((c + i) % 32), s);
        chk(8'(pin_oe_n), {5'h00, ~dir});
        chk(8'(pin_out), 8'(want));
        chk(8'(level), 8'(want));
      end
    end
    $display("routing test done");
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    #1;
    chk(8'(pin_oe_n), 8'h07);
    chk(8'(pin_out), 8'h00);
    rd(GPOSEL_OFS_PIN_TWO, 8'h00);
    rd(GPOSEL_OFS_PIN_ZERO, 8'h00);
    $display("reset test done");
    print_verdict();
  end

  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
